// ===== logic/srdl_pkg.sv
// Purpose: Shared constants for the serial driver latch block.
// Assumes: One system clock; all pin inputs synchronous to it.
// Notes:   Widths and reset values used by the top module of the block.
`default_nettype none
package srdl_pkg;

    localparam int unsigned SRDL_STAGES     = 8;
    localparam logic        SRDL_EDGE_RST   = 1'b0;
    localparam logic        SRDL_CHAIN_RST  = 1'b0;
    localparam logic [7:0]  SRDL_BANK_RST   = 8'h00;
    localparam logic        SRDL_PIN_LEVEL  = 1'b0;

endpackage : srdl_pkg
`default_nettype wire

// ===== logic/srdl_ob_if.sv
// Purpose: Carries the storage latch and output controls to the sink stage.
// Assumes: Driven from the core of the serial driver latch.
// Notes:   The stage modport returns the pin drive signals.
`timescale 1ns/1ps
`default_nettype none
interface srdl_ob_if #(parameter int unsigned WIDTH = 8);
    logic [WIDTH-1:0] latch_bits;
    logic             clear_n;
    logic             enable_n;
    logic [WIDTH-1:0] buffer_bits;
    logic [WIDTH-1:0] drain_on;

    modport core  (output latch_bits, output clear_n, output enable_n,
                   input buffer_bits, input drain_on);
    modport stage (input latch_bits, input clear_n, input enable_n,
                   output buffer_bits, output drain_on);
endinterface : srdl_ob_if
`default_nettype wire

// ===== logic/srdl_sink_stage.sv
// Purpose: Output buffer and open-drain sink enables.
// Assumes: Latch bits come from flip-flops in the core.
// Notes:   Purely combinational so the enable acts without a clock edge.
`timescale 1ns/1ps
`default_nettype none
module srdl_sink_stage (
    srdl_ob_if.stage ob
);
    import srdl_pkg::*;

    wire pass_ok = ob.clear_n & ~ob.enable_n;

    // The buffer shows the latch only while not cleared and enabled.
    assign ob.buffer_bits = pass_ok ? ob.latch_bits : '0;
    // A one in the buffer switches the sink on; a zero leaves it off.
    assign ob.drain_on    = ob.buffer_bits;

endmodule : srdl_sink_stage
`default_nettype wire

// ===== logic/srdl_top.sv
// Purpose: Serial-in parallel-out shift register, storage latch and
//          eight open-drain sink outputs with a cascade output.
// Assumes: Pin clocks are sampled by sys_clk_in at 40 MHz, so each pin
//          level must hold for at least two system clock cycles.
// Notes:   Edges of the pin clocks are found by comparing with the last
//          sampled level; the clear pin is a level, not an edge.
//
// Notes on behaviour
// - Eight stages shift onward on shift clock rise.
// - Latch copies all stages on latch clock rise.
// - Clear low zeroes stages, latch and chain.
// - Clear high passes latch to output buffer.
// - Enable high forces all buffer bits low.
// - Enable low: buffer follows latch without clock.
// - Buffer one turns sink on, zero off.
// - Chain output changes on shift clock fall.
`timescale 1ns/1ps
`default_nettype none
module srdl_top #(
    parameter int unsigned STAGES = srdl_pkg::SRDL_STAGES
) (
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              shift_data_in,
    input  wire logic              shift_clock_in,
    input  wire logic              latch_clock_in,
    input  wire logic              bank_clear_n_in,
    input  wire logic              output_enable_n_in,
    output logic                   chain_data_out,
    output logic [STAGES-1:0]      sink_level_out,
    output logic [STAGES-1:0]      sink_oe_out
);
    import srdl_pkg::*;

    logic              shift_clk_q_ff;
    logic              latch_clk_q_ff;
    logic [STAGES-1:0] stage_ff;
    logic [STAGES-1:0] nxt_stage;
    logic [STAGES-1:0] latch_ff;
    logic [STAGES-1:0] nxt_latch;
    logic              chain_ff;
    logic              nxt_chain;
    logic [STAGES-1:0] shift_src;

    // Edge detection on the sampled pin clocks. The detectors reset low,
    // the idle level of both pin clocks, so no false edge follows reset.
    wire shift_rise = shift_clock_in & ~shift_clk_q_ff;
    wire shift_fall = ~shift_clock_in & shift_clk_q_ff;
    wire latch_rise = latch_clock_in & ~latch_clk_q_ff;
    wire clear_on   = ~bank_clear_n_in;

    // Stage zero takes the serial pin; each later stage its neighbour.
    assign shift_src = {stage_ff[STAGES-2:0], shift_data_in};

    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : g_stage
            assign nxt_stage[gi] = clear_on   ? 1'b0          :
                                   shift_rise ? shift_src[gi] :
                                                stage_ff[gi];
        end
    endgenerate

    // The latch sees the stages as they stood before this cycle, so a
    // shift and a latch edge in one cycle latch the older pattern, as
    // when both pin clocks rise together.
    assign nxt_latch = clear_on   ? '0       :
                       latch_rise ? stage_ff :
                                    latch_ff;

    // Updating on the fall gives a following device half a shift period
    // of hold margin on its own rising edge.
    assign nxt_chain = clear_on   ? 1'b0             :
                       shift_fall ? stage_ff[STAGES-1] :
                                    chain_ff;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_clk_q_ff <= SRDL_EDGE_RST;
            latch_clk_q_ff <= SRDL_EDGE_RST;
        end else begin
            shift_clk_q_ff <= shift_clock_in;
            latch_clk_q_ff <= latch_clock_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage_ff <= STAGES'(SRDL_BANK_RST);
            latch_ff <= STAGES'(SRDL_BANK_RST);
            chain_ff <= SRDL_CHAIN_RST;
        end else begin
            stage_ff <= nxt_stage;
            latch_ff <= nxt_latch;
            chain_ff <= nxt_chain;
        end
    end

    srdl_ob_if #(.WIDTH(STAGES)) ob_if ();

    assign ob_if.latch_bits = latch_ff;
    assign ob_if.clear_n    = bank_clear_n_in;
    assign ob_if.enable_n   = output_enable_n_in;

    srdl_sink_stage u_sink (
        .ob (ob_if.stage)
    );

    // Open-drain pins only ever pull low; the enable carries the data.
    assign sink_level_out = {STAGES{SRDL_PIN_LEVEL}};
    assign sink_oe_out    = ob_if.drain_on;
    assign chain_data_out = chain_ff;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Clear gates the sinks at once but zeroes the registers one cycle
    // later, so the register checks look at the following edge.

    sequence s_clean_shift;
        shift_rise && bank_clear_n_in;
    endsequence

    sequence s_clean_fall;
        shift_fall && bank_clear_n_in;
    endsequence

    sequence s_clean_latch;
        latch_rise && bank_clear_n_in;
    endsequence

    sequence s_hold_latch;
        !latch_rise && bank_clear_n_in;
    endsequence

    // The host holds each shift clock level three cycles, so two quiet
    // edges stand between a seen rise and the fall that follows it.
    sequence s_gap_no_fall;
        (!shift_rise && !shift_fall && bank_clear_n_in)[*2];
    endsequence

    a_shift_stage_move: assert property (
        s_clean_shift |=> stage_ff == {$past(stage_ff[STAGES-2:0]),
                                       $past(shift_data_in)})
        else $error("Shift stages did not move on shift clock rise.");

    a_stage_idle_hold: assert property (
        !shift_rise && bank_clear_n_in |=> $stable(stage_ff))
        else $error("Shift stages changed without a shift clock rise.");

    a_latch_copy_all: assert property (
        s_clean_latch |=> latch_ff == $past(stage_ff))
        else $error("Latch did not copy the shift stages.");

    a_latch_hold_value: assert property (
        s_hold_latch |=> $stable(latch_ff))
        else $error("Latch changed without a latch clock rise.");

    a_clear_all_regs: assert property (
        !bank_clear_n_in |=> stage_ff == '0 && latch_ff == '0
                             && chain_data_out == 1'b0)
        else $error("Clear did not zero every register.");

    a_clear_latch_block: assert property (
        !bank_clear_n_in && latch_rise |=> latch_ff == '0)
        else $error("Latch took data while clear was low.");

    a_buffer_pass_latch: assert property (
        bank_clear_n_in && !output_enable_n_in |-> sink_oe_out == latch_ff)
        else $error("Sinks do not follow the latch while enabled.");

    a_disable_sinks_off: assert property (
        output_enable_n_in |-> sink_oe_out == '0)
        else $error("A sink is on while outputs are disabled.");

    a_enable_no_wait: assert property (
        $fell(output_enable_n_in) && bank_clear_n_in
        |-> sink_oe_out == latch_ff)
        else $error("Sinks waited for a clock after enable went low.");

    a_sink_pin_low: assert property (
        sink_level_out == '0)
        else $error("A sink pin drives a high level.");

    a_chain_on_fall: assert property (
        s_clean_fall |=> chain_data_out == $past(stage_ff[STAGES-1]))
        else $error("Chain output did not take the last stage on fall.");

    a_chain_rise_hold: assert property (
        s_clean_shift ##1 (!shift_fall && bank_clear_n_in)[*2]
        |-> $stable(chain_data_out))
        else $error("Chain output moved away from a shift clock fall.");

    a_chain_eight_shift: assert property (
        (s_clean_shift ##1 s_gap_no_fall ##1 s_clean_fall) |=>
        chain_data_out == $past(shift_src[STAGES-1], 4))
        else $error("Chain output is not the stage shifted in last.");

    a_chain_idle_hold: assert property (
        !shift_fall && bank_clear_n_in |=> $stable(chain_data_out))
        else $error("Chain output moved without a shift clock fall.");

    a_shift_clear_block: assert property (
        !bank_clear_n_in && shift_rise |=> stage_ff == '0)
        else $error("Shift stages took data while clear was low.");

    a_clear_sinks_off: assert property (
        !bank_clear_n_in |-> sink_oe_out == '0)
        else $error("A sink is on while clear is low.");

    a_disable_at_once: assert property (
        $rose(output_enable_n_in) |-> sink_oe_out == '0)
        else $error("Sinks stayed on after outputs were disabled.");

    a_sink_only_ones: assert property (
        (sink_oe_out & ~latch_ff) == '0)
        else $error("A sink is on for a latch bit that is zero.");

endmodule : srdl_top
`default_nettype wire

// ===== tb/srdl_host_model.sv
// Purpose: Host controller model driving serial data and pin clocks.
// Assumes: Each pin level is held two or three system clock cycles.
// Notes:   Data is inverted after each fall so stale bits never match.
`timescale 1ns/1ps
`default_nettype none
module srdl_host_model (
    input  wire logic clk_in,
    output logic      sdata_out,
    output logic      sclk_out,
    output logic      lclk_out
);
    initial begin
        sdata_out = 1'b0;
        sclk_out  = 1'b0;
        lclk_out  = 1'b0;
    end

    task automatic rise(input logic b);
        @(posedge clk_in);
        sdata_out <= b;
        sclk_out  <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask : rise

    task automatic fall();
        @(posedge clk_in);
        sclk_out  <= 1'b0;
        sdata_out <= ~sdata_out;
        repeat (2) @(posedge clk_in);
    endtask : fall

    task automatic pulse_latch();
        @(posedge clk_in);
        lclk_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        lclk_out <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : pulse_latch
endmodule : srdl_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the serial driver latch.
// Assumes: Host model owns the serial pins; bench owns clear and enable.
// Notes:   Chain output exposes stage state, so clear is seen there too.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import srdl_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        clr_n = 1'b1;
    logic        en_n = 1'b0;
    logic        sdata, sclk, lclk, chain;
    logic [7:0]  oe, lvl, v, exp_stage, exp_latch;
    logic [31:0] rnd = 32'h000167cb;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #12.5 sys_clk_in = ~sys_clk_in;

    srdl_host_model srdl_host_model_i (.clk_in(sys_clk_in),
        .sdata_out(sdata), .sclk_out(sclk), .lclk_out(lclk));
    srdl_top srdl_top_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .shift_data_in(sdata), .shift_clock_in(sclk),
        .latch_clock_in(lclk), .bank_clear_n_in(clr_n),
        .output_enable_n_in(en_n), .chain_data_out(chain),
        .sink_level_out(lvl), .sink_oe_out(oe));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] exp_sink(input logic [7:0] l,
                                            input logic e, input logic c);
        return (e | ~c) ? 8'h00 : l;
    endfunction : exp_sink

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, want, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Chain is checked after the rise (must hold) and after the fall.
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            srdl_host_model_i.rise(b[i]);
            #1 check("chain_hold", {7'h00, chain},
                     {7'h00, exp_stage[7]});
            exp_stage = {exp_stage[6:0], b[i]};
            srdl_host_model_i.fall();
            #1 check("chain", {7'h00, chain},
                     {7'h00, exp_stage[7]});
        end
        check("sink_no_latch", oe,
              exp_sink(exp_latch, en_n, clr_n));
    endtask : shift_byte

    task automatic set_pins(input logic c, input logic e);
        @(posedge sys_clk_in);
        clr_n <= c;
        en_n  <= e;
        #1 check("sink_oe", oe, exp_sink(exp_latch, e, c));
    endtask : set_pins

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        exp_stage = 8'h00;
        exp_latch = 8'h00;
        repeat (16) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        #1 check("reset_sink", oe, 8'h00);
        for (int t = 0; t < 10; t++) begin
            rnd = lfsr_next(rnd);
            v = (t == 0) ? 8'hff : (t == 1) ? 8'h00 : rnd[7:0];
            shift_byte(v);
            srdl_host_model_i.pulse_latch();
            exp_latch = exp_stage;
            #1 check("sink_latched", oe,
                     exp_sink(exp_latch, en_n, clr_n));
            check("sink_level", lvl, 8'h00);
            set_pins(1'b1, rnd[9]);
            set_pins(1'b1, 1'b0);
            $display("test byte %0d done", t);
        end
        // Pin clocks run while clear is low; nothing may be taken.
        set_pins(1'b0, 1'b0);
        srdl_host_model_i.rise(1'b1);
        srdl_host_model_i.fall();
        srdl_host_model_i.pulse_latch();
        exp_stage = 8'h00;
        exp_latch = 8'h00;
        set_pins(1'b1, 1'b0);
        check("chain_clear", {7'h00, chain}, 8'h00);
        shift_byte(8'h81);
        $display("test clear done");
        srdl_host_model_i.pulse_latch();
        exp_latch = exp_stage;
        #1 check("sink_latched", oe,
                 exp_sink(exp_latch, en_n, clr_n));
        @(posedge sys_clk_in);
        arst_n_in <= 1'b0;
        #1 check("reset_mid_sink", oe, 8'h00);
        check("reset_mid_chain", {7'h00, chain}, 8'h00);
        exp_stage = 8'h00;
        exp_latch = 8'h00;
        @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        shift_byte(8'h3c);
        $display("test reset done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
